// >>> fsbu_cpu_bfm.sv
// processor-side register bus master for the flash security block
// assumes tasks are entered just after a rising edge of clk
`timescale 1ns/1ns
module fsbu_cpu_bfm (
  input wire logic clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  //////////////////////////////////////////////////////////////////////////////
  // ready is judged at the falling edge, so the next rising edge takes the item
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do @(negedge clk); while (!(awready && wready));
    @(posedge clk);
    {awvalid, wvalid, awaddr, wdata} <= {2'h0, ~a, ~d}; // released lines show no stale value
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(negedge clk); while (!arready);
    @(posedge clk);
    {arvalid, araddr} <= {1'b0, ~a};
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
endmodule : fsbu_cpu_bfm

// >>> fsbu_opt_mem.sv
// options field store: backdoor key words and the security word
// assumes power-on reset alone loads it; chip reset leaves it intact
`timescale 1ns/1ns
module fsbu_opt_mem #(
  parameter int DEPTH = fsbu_pkg::OPT_DEPTH,
  parameter int WIDTH = 16,
  parameter logic [16*fsbu_pkg::OPT_DEPTH-1:0] INIT = fsbu_pkg::OPT_INIT
) (
  input wire logic clk,
  input wire logic por,
  input wire fsbu_pkg::fsbu_mwr_s wr,
  input wire logic erase,
  input wire logic [2:0] a_addr,
  output logic [WIDTH-1:0] a_data,
  input wire logic [2:0] b_addr,
  output logic [WIDTH-1:0] b_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];

  // erase drives every word to ones, as a blank array reads
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
      if (erase) begin
        mem_d[i] = {WIDTH{1'b1}};
      end else if (wr.en && wr.idx == i[2:0]) begin
        mem_d[i] = wr.data;
      end
    end
  end

  // only power-on loads the store with its image, so keys survive a chip reset
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= INIT[i*16 +: 16];
      end
      a_data <= '0;
      b_data <= '0;
    end else begin
      mem_q <= mem_d;
      a_data <= mem_q[a_addr];
      b_data <= mem_q[b_addr];
    end
  end
endmodule : fsbu_opt_mem

// >>> fsbu_pkg.sv
// constants and carrier types shared by the flash security block
// assumes a 32-bit AXI4-Lite register bus and a 16-bit options store
package fsbu_pkg;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] OFS_SEC = 12'h000;
  localparam logic [11:0] OFS_CFG = 12'h004;
  localparam logic [11:0] OFS_PROT = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;
  localparam logic [11:0] OFS_CMD = 12'h010;
  localparam logic [6:0] OFS_WIN_HI = 7'h08; // window 0x100..0x110
  // options store layout: four key words, then the security word
  localparam int OPT_DEPTH = 8;
  localparam logic [2:0] KEY_LAST_IDX = 3'h3;
  localparam logic [2:0] SEC_IDX = 3'h4;
  localparam logic [2:0] KEY_COUNT = 3'h4;
  localparam logic [16*OPT_DEPTH-1:0] OPT_INIT =
    128'hFFFF_FFFF_FFFF_FF80_DEF0_9ABC_5678_1234;
  // security byte fields
  localparam int SEC_LSB = 0;
  localparam int KEY_EN_LSB = 6;
  localparam logic [1:0] SEC_UNSECURE = 2'h2;
  localparam logic [1:0] KEY_EN_OPEN = 2'h2;
  localparam logic [7:0] SEC_RST = 8'h00;
  // configuration register bits
  localparam int CFG_BE_IE = 7;
  localparam int CFG_CD_IE = 6;
  localparam int CFG_KEY_ACCESS = 5;
  localparam int CFG_BANK_LSB = 0;
  // status register bits
  localparam int ST_BE = 7;
  localparam int ST_CD = 6;
  localparam int ST_ACCERR = 4;
  // protection register
  localparam logic [7:0] PROT_RST = 8'hFF;
  localparam int PROT_TOP_OPEN = 7; // set means top sector unprotected
  // command codes
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_PROG = 8'h20;
  localparam logic [7:0] CMD_SECT = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  localparam logic [15:0] CMD_BUSY_CYCLES = 16'h0010;
  localparam logic [31:0] RD_INVALID = 32'h0000_DEAD;
  localparam logic [15:0] KEY_ZERO = 16'h0000;
  localparam logic [15:0] KEY_ONES = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic be_ie;
    logic cd_ie;
    logic key_acc;
    logic [1:0] bank;
  } fsbu_cfg_s;

  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [15:0] data;
  } fsbu_mwr_s;

  typedef enum logic [3:0] {
    UL_IDLE = 4'h1,
    UL_ARMED = 4'h2,
    UL_CHECK = 4'h4,
    UL_LOCK = 4'h8
  } fsbu_ul_e;

  typedef enum logic [1:0] {
    CM_IDLE = 2'h1,
    CM_BUSY = 2'h2
  } fsbu_cm_e;
endpackage : fsbu_pkg

// >>> fsbu_top.sv
// flash security, backdoor unlock, command gate and interrupt request
// assumes an AXI4-Lite master on REF_CLK and debug pins from elsewhere
`timescale 1ns/1ns
module fsbu_top #(
  parameter logic [15:0] CMD_CYCLES = fsbu_pkg::CMD_BUSY_CYCLES,
  parameter logic [1:0] BANK_ID = 2'h0
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic DEBUG_HALTED,
  input wire logic SPECIAL_SINGLE_CHIP,
  output logic SECURED,
  output logic FLASH_IRQ
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  logic [1:0] pin_m_q, pin_q;
  logic dbg, ssc;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_m_q <= 2'h0;
      pin_q <= 2'h0;
    end else begin
      pin_m_q <= {SPECIAL_SINGLE_CHIP, DEBUG_HALTED};
      pin_q <= pin_m_q;
    end
  end
  assign dbg = pin_q[0];
  assign ssc = pin_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  fsbu_pkg::fsbu_ul_e ul_q, ul_d;
  fsbu_pkg::fsbu_cm_e cm_q, cm_d;
  fsbu_pkg::fsbu_cfg_s cfg_q, cfg_d;
  fsbu_pkg::fsbu_mwr_s mwr;
  logic [7:0] sec_q, sec_d, prot_q, prot_d, cmd_q, cmd_d;
  logic [1:0] boot_q, boot_d;
  logic prot_once_q, prot_once_d, be_q, be_d, cd_q, cd_d, err_q, err_d;
  logic buf_q, buf_d, cmdv_q, cmdv_d, match_q, match_d, irq_q, irq_d;
  logic [2:0] cnt_q, cnt_d, bidx_q, bidx_d, widx_q, widx_d, raddr_q;
  logic [15:0] bdat_q, bdat_d, key_q, key_d, busy_q, busy_d;
  logic bvalid_q, bvalid_d, rd_pend_q, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [11:0] raw_q;
  logic [15:0] mem_a, mem_b;
  logic erase, secured, refuse;

  ////////////////////////////////////////////////////////////////////////////
  // write decode: address and data are taken together in one beat
  logic wr_fire, ar_fire, w_sec, w_cfg, w_prot, w_stat, w_cmd, w_win, w_map;
  logic [2:0] w_idx;
  logic [15:0] w_key;
  assign wr_fire = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q & (ul_q != fsbu_pkg::UL_CHECK);
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY = wr_fire;
  assign w_idx = S_AXI_AWADDR[4:2];
  assign w_key = S_AXI_WDATA[15:0];
  assign w_sec = S_AXI_AWADDR == fsbu_pkg::OFS_SEC;
  assign w_cfg = wr_fire & S_AXI_WSTRB[0] & (S_AXI_AWADDR == fsbu_pkg::OFS_CFG);
  assign w_prot = wr_fire & S_AXI_WSTRB[0] & (S_AXI_AWADDR == fsbu_pkg::OFS_PROT);
  assign w_stat = wr_fire & S_AXI_WSTRB[0] & (S_AXI_AWADDR == fsbu_pkg::OFS_STAT);
  assign w_cmd = wr_fire & S_AXI_WSTRB[0] & (S_AXI_AWADDR == fsbu_pkg::OFS_CMD);
  assign w_map = w_sec | (S_AXI_AWADDR == fsbu_pkg::OFS_CFG) | (S_AXI_AWADDR == fsbu_pkg::OFS_PROT)
    | (S_AXI_AWADDR == fsbu_pkg::OFS_STAT) | (S_AXI_AWADDR == fsbu_pkg::OFS_CMD)
    | (S_AXI_AWADDR[11:5] == fsbu_pkg::OFS_WIN_HI && w_idx <= fsbu_pkg::SEC_IDX
       && S_AXI_AWADDR[1:0] == 2'h0);
  assign w_win = wr_fire & (&S_AXI_WSTRB[1:0]) & (S_AXI_AWADDR[11:5] == fsbu_pkg::OFS_WIN_HI)
    & (w_idx <= fsbu_pkg::SEC_IDX) & (S_AXI_AWADDR[1:0] == 2'h0);

  assign secured = sec_q[fsbu_pkg::SEC_LSB +: 2] != fsbu_pkg::SEC_UNSECURE;
  assign refuse = dbg & ssc; // backdoor through debug in single-chip mode

  ////////////////////////////////////////////////////////////////////////////
  // configuration, protection and boot-time security load
  always_comb begin
    cfg_d = cfg_q;
    prot_d = prot_q;
    prot_once_d = prot_once_q;
    boot_d = {boot_q[0], 1'b0};
    sec_d = sec_q;
    if (w_cfg) begin
      cfg_d.be_ie = S_AXI_WDATA[fsbu_pkg::CFG_BE_IE];
      cfg_d.cd_ie = S_AXI_WDATA[fsbu_pkg::CFG_CD_IE];
      cfg_d.key_acc = S_AXI_WDATA[fsbu_pkg::CFG_KEY_ACCESS];
      cfg_d.bank = S_AXI_WDATA[fsbu_pkg::CFG_BANK_LSB +: 2];
    end
    // outside debug the protection register takes one write per reset
    if (w_prot && (dbg || !prot_once_q)) begin
      prot_d = S_AXI_WDATA[7:0];
      prot_once_d = 1'b1;
    end
    if (boot_q[1]) begin
      sec_d = mem_a[7:0];
    end
    // success forces only the live image; the stored byte is untouched
    if (ul_q == fsbu_pkg::UL_ARMED && !cfg_q.key_acc && cnt_q == fsbu_pkg::KEY_COUNT
        && match_q) begin
      sec_d[fsbu_pkg::SEC_LSB +: 2] = fsbu_pkg::SEC_UNSECURE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // backdoor unlock sequencer
  always_comb begin
    ul_d = ul_q;
    cnt_d = cnt_q;
    match_d = match_q;
    key_d = key_q;
    widx_d = widx_q;
    case (ul_q)
      fsbu_pkg::UL_IDLE: begin
        if (cfg_q.key_acc && !refuse && secured
            && sec_q[fsbu_pkg::KEY_EN_LSB +: 2] == fsbu_pkg::KEY_EN_OPEN) begin
          ul_d = fsbu_pkg::UL_ARMED;
          cnt_d = 3'h0;
          match_d = 1'b1;
        end
      end
      fsbu_pkg::UL_ARMED: begin
        if (w_win) begin
          if (w_idx != cnt_q || cnt_q == fsbu_pkg::KEY_COUNT
              || w_key == fsbu_pkg::KEY_ZERO || w_key == fsbu_pkg::KEY_ONES) begin
            ul_d = fsbu_pkg::UL_LOCK;
          end else begin
            ul_d = fsbu_pkg::UL_CHECK;
            key_d = w_key;
            widx_d = w_idx;
          end
        end else if (!cfg_q.key_acc) begin
          // judged only on the clear, so a mismatch is caught late but surely
          if (cnt_q == fsbu_pkg::KEY_COUNT && match_q) begin
            ul_d = fsbu_pkg::UL_IDLE;
          end else begin
            ul_d = fsbu_pkg::UL_LOCK;
          end
        end
      end
      fsbu_pkg::UL_CHECK: begin
        match_d = match_q & (mem_a == key_q);
        cnt_d = cnt_q + 3'h1;
        ul_d = fsbu_pkg::UL_ARMED;
      end
      fsbu_pkg::UL_LOCK: ul_d = fsbu_pkg::UL_LOCK;
      default: ul_d = fsbu_pkg::UL_LOCK;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // command engine: one buffered word, one command, no pending queue
  logic launch, cmd_ok, key_win;
  assign key_win = ul_q == fsbu_pkg::UL_ARMED;
  assign launch = w_stat & S_AXI_WDATA[fsbu_pkg::ST_BE] & be_q & cmdv_q;
  always_comb begin
    cmd_ok = cmd_q == fsbu_pkg::CMD_MASS || cmd_q == fsbu_pkg::CMD_SECT
      || cmd_q == fsbu_pkg::CMD_VERIFY || (cmd_q == fsbu_pkg::CMD_PROG && buf_q);
    if (dbg && secured && ssc && cmd_q != fsbu_pkg::CMD_MASS) begin
      cmd_ok = 1'b0;
    end
    // options word programming needs unsecured chip and open top sector
    if (cmd_q == fsbu_pkg::CMD_PROG
        && (secured || !prot_q[fsbu_pkg::PROT_TOP_OPEN])) begin
      cmd_ok = 1'b0;
    end
    cm_d = cm_q;
    busy_d = busy_q;
    be_d = be_q;
    cd_d = cd_q;
    err_d = err_q;
    buf_d = buf_q;
    cmdv_d = cmdv_q;
    bidx_d = bidx_q;
    bdat_d = bdat_q;
    cmd_d = cmd_q;
    mwr = '0;
    erase = 1'b0;
    if (w_stat && S_AXI_WDATA[fsbu_pkg::ST_ACCERR]) begin
      err_d = 1'b0;
    end
    if (w_win && !key_win) begin
      if (!be_q || buf_q) begin
        err_d = 1'b1;
      end else begin
        buf_d = 1'b1;
        bidx_d = w_idx;
        bdat_d = w_key;
      end
    end
    if (w_cmd) begin
      cmd_d = S_AXI_WDATA[7:0];
      cmdv_d = 1'b1;
      err_d = err_d | cmdv_q;
    end
    if (w_stat && !S_AXI_WDATA[fsbu_pkg::ST_BE] && (buf_q || cmdv_q)) begin
      buf_d = 1'b0;
      cmdv_d = 1'b0;
      err_d = 1'b1;
    end
    case (cm_q)
      fsbu_pkg::CM_IDLE: begin
        if (launch) begin
          buf_d = 1'b0;
          cmdv_d = 1'b0;
          if (cmd_ok && !err_q) begin
            cm_d = fsbu_pkg::CM_BUSY;
            busy_d = CMD_CYCLES;
            be_d = 1'b0;
            cd_d = 1'b0;
          end else begin
            err_d = 1'b1;
          end
        end
      end
      fsbu_pkg::CM_BUSY: begin
        busy_d = busy_q - 16'h0001;
        if (busy_q == 16'h0001) begin
          cm_d = fsbu_pkg::CM_IDLE;
          be_d = 1'b1;
          cd_d = 1'b1;
          mwr.en = cmd_q == fsbu_pkg::CMD_PROG;
          mwr.idx = bidx_q;
          mwr.data = bdat_q;
          erase = cmd_q == fsbu_pkg::CMD_MASS || cmd_q == fsbu_pkg::CMD_SECT;
        end
      end
      default: cm_d = fsbu_pkg::CM_IDLE;
    endcase
    // irq is a level; bank qualification stops idle unselected banks firing
    irq_d = (cfg_q.bank == BANK_ID)
      & ((be_q & cfg_q.be_ie) | (cd_q & cfg_q.cd_ie));
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answers: write in one cycle, read in two for the registered store
  logic rsel_win;
  assign ar_fire = S_AXI_ARVALID & ~rd_pend_q & ~rvalid_q;
  assign S_AXI_ARREADY = ar_fire;
  assign rsel_win = raw_q[11:5] == fsbu_pkg::OFS_WIN_HI && raddr_q <= fsbu_pkg::SEC_IDX
    && raw_q[1:0] == 2'h0;
  always_comb begin
    bvalid_d = bvalid_q & ~S_AXI_BREADY;
    bresp_d = bresp_q;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = w_map ? fsbu_pkg::RESP_OKAY : fsbu_pkg::RESP_SLVERR;
    end
    rvalid_d = rvalid_q & ~S_AXI_RREADY;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_pend_q) begin
      rvalid_d = 1'b1;
      rresp_d = fsbu_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (raw_q)
        fsbu_pkg::OFS_SEC: rdata_d = {23'h0, secured, sec_q};
        fsbu_pkg::OFS_CFG: rdata_d = {24'h0, cfg_q.be_ie, cfg_q.cd_ie, cfg_q.key_acc,
                                      3'h0, cfg_q.bank};
        fsbu_pkg::OFS_PROT: rdata_d = {24'h0, prot_q};
        fsbu_pkg::OFS_STAT: rdata_d = {24'h0, be_q, cd_q, 1'b0, err_q, 4'h0};
        fsbu_pkg::OFS_CMD: rdata_d = {24'h0, cmd_q};
        default: begin
          if (rsel_win) begin
            rdata_d = cfg_q.key_acc ? fsbu_pkg::RD_INVALID : {16'h0, mem_b};
          end else begin
            rresp_d = fsbu_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset also kills any running command
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ul_q <= fsbu_pkg::UL_IDLE;
      cm_q <= fsbu_pkg::CM_IDLE;
      cfg_q <= '0;
      sec_q <= fsbu_pkg::SEC_RST;
      prot_q <= fsbu_pkg::PROT_RST;
      boot_q <= 2'h1;
      {prot_once_q, err_q, buf_q, cmdv_q, match_q, irq_q} <= 6'h00;
      {be_q, cd_q} <= 2'h3;
      {cnt_q, bidx_q, widx_q, raddr_q} <= 12'h000;
      {bdat_q, key_q, busy_q} <= 48'h0;
      cmd_q <= 8'h00;
      raw_q <= 12'h000;
      {bvalid_q, rd_pend_q, rvalid_q} <= 3'h0;
      {bresp_q, rresp_q} <= 4'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ul_q <= ul_d;
      cm_q <= cm_d;
      cfg_q <= cfg_d;
      sec_q <= sec_d;
      prot_q <= prot_d;
      boot_q <= boot_d;
      {prot_once_q, err_q, buf_q, cmdv_q, match_q, irq_q} <=
        {prot_once_d, err_d, buf_d, cmdv_d, match_d, irq_d};
      {be_q, cd_q} <= {be_d, cd_d};
      {cnt_q, bidx_q, widx_q} <= {cnt_d, bidx_d, widx_d};
      {bdat_q, key_q, busy_q} <= {bdat_d, key_d, busy_d};
      cmd_q <= cmd_d;
      if (ar_fire) begin
        raw_q <= S_AXI_ARADDR;
        raddr_q <= S_AXI_ARADDR[4:2];
      end
      {bvalid_q, rd_pend_q, rvalid_q} <= {bvalid_d, ar_fire, rvalid_d};
      {bresp_q, rresp_q} <= {bresp_d, rresp_d};
      rdata_q <= rdata_d;
    end
  end

  fsbu_opt_mem u_mem (
    .clk(REF_CLK),
    .por(POR),
    .wr(mwr),
    .erase(erase),
    .a_addr(boot_q[0] ? fsbu_pkg::SEC_IDX : w_idx),
    .a_data(mem_a),
    .b_addr(S_AXI_ARADDR[4:2]),
    .b_data(mem_b)
  );

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign SECURED = secured;
  assign FLASH_IRQ = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_lock_hold;
    ul_q == fsbu_pkg::UL_LOCK |=> ul_q == fsbu_pkg::UL_LOCK [*4];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock left");
  property p_forbid;
    key_win && w_win && (w_key == fsbu_pkg::KEY_ZERO || w_key == fsbu_pkg::KEY_ONES)
      |=> ul_q == fsbu_pkg::UL_LOCK;
  endproperty
  a_forbid: assert property (p_forbid) else $error("forbidden key not locked");
  property p_order;
    key_win && w_win && w_idx != cnt_q |=> ul_q == fsbu_pkg::UL_LOCK;
  endproperty
  a_order: assert property (p_order) else $error("wrong order not locked");
  property p_unlock;
    key_win && !cfg_q.key_acc && cnt_q == fsbu_pkg::KEY_COUNT && match_q && !w_win
      |=> !SECURED && sec_q[1:0] == 2'h2;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock missed");
  property p_irq;
    1'b1 |=> FLASH_IRQ == ($past(cfg_q.bank) == BANK_ID
      && (($past(be_q) && $past(cfg_q.be_ie)) || ($past(cd_q) && $past(cfg_q.cd_ie))));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_done;
    cm_q == fsbu_pkg::CM_BUSY && busy_q == 16'h0001 |=> be_q && cd_q && cm_q == fsbu_pkg::CM_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("completion flags not set");
  property p_dbg_gate;
    launch && dbg && ssc && secured && cmd_q != fsbu_pkg::CMD_MASS
      |=> err_q && cm_q == fsbu_pkg::CM_IDLE;
  endproperty
  a_dbg_gate: assert property (p_dbg_gate) else $error("debug command not refused");
  property p_no_store;
    ul_q == fsbu_pkg::UL_CHECK |-> !mwr.en && !erase ##1 $stable(prot_q) || w_prot;
  endproperty
  a_no_store: assert property (p_no_store) else $error("unlock touched store");
  property p_inval;
    rd_pend_q && rsel_win && cfg_q.key_acc |=> S_AXI_RDATA == fsbu_pkg::RD_INVALID;
  endproperty
  a_inval: assert property (p_inval) else $error("array read valid under key access");
  property p_boot;
    boot_q[1] && mem_a[1:0] != 2'h2 |=> SECURED;
  endproperty
  a_boot: assert property (p_boot) else $error("secure byte ignored");
endmodule : fsbu_top

// >>> tb.sv
// self-checking bench for the flash security block
// assumes the options store holds its power-on image
`timescale 1ns/1ns
module tb;
  logic clk, rst, por, dbg, ssc, secured, irq;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, awready, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] bad;
  int miscompares, total_checks, cyc, c, n;
  fsbu_top #(.CMD_CYCLES(16'h0020), .BANK_ID(2'h0)) u_dut (.REF_CLK(clk), .RST(rst), .POR(por),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DEBUG_HALTED(dbg), .SPECIAL_SINGLE_CHIP(ssc), .SECURED(secured), .FLASH_IRQ(irq));
  fsbu_cpu_bfm u_cpu (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .awready(awready), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] key_of(input int i);
    return fsbu_pkg::OPT_INIT[16*i +: 16];
  endfunction : key_of
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic reset_chip;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : reset_chip
  // key words go to (i + skip) mod 4, so skip breaks the order and n > 4 adds a word
  task automatic attempt(input int cnt, input int skip, input int bi, input logic [15:0] bv);
    u_cpu.wr(12'h004, 32'h20, r);
    for (int i = 0; i < cnt; i++)
      u_cpu.wr(12'h100 + 12'(4 * ((i + skip) % 4)),
        {16'h0, (i == bi) ? bv : key_of((i + skip) % 4)}, r);
    u_cpu.wr(12'h004, 32'h0, r);
    repeat (2) @(posedge clk);
  endtask : attempt
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard: far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {rst, por, dbg, ssc} = 4'hC;
    d = $urandom(90870);
    repeat (2) @(posedge clk);
    {rst, por} <= 2'h0;
    repeat (3) @(posedge clk);
    u_cpu.rd(12'h000, d, r);
    chk("security", d, 32'h180);
    chk("secured", {31'h0, secured}, 32'h1);
    u_cpu.rd(12'h020, d, r);
    chk("rresp", {30'h0, r}, {30'h0, fsbu_pkg::RESP_SLVERR});
    u_cpu.wr(12'h004, 32'h20, r);
    chk("bresp", {30'h0, r}, {30'h0, fsbu_pkg::RESP_OKAY});
    u_cpu.rd(12'h100, d, r);
    chk("window", d, fsbu_pkg::RD_INVALID);
    // clearing key access with no word written locks, so only a reset frees it
    u_cpu.wr(12'h004, 32'h0, r);
    reset_chip();
    attempt(4, 0, 9, 16'h0);
    chk("secured", {31'h0, secured}, 32'h0);
    u_cpu.rd(12'h000, d, r);
    chk("security", d, 32'h082);
    u_cpu.rd(12'h110, d, r);
    chk("secword", d, {16'h0, key_of(4)});
    u_cpu.rd(12'h100, d, r);
    chk("key0", d, {16'h0, key_of(0)});
    u_cpu.rd(12'h008, d, r);
    chk("prot", d, {24'h0, fsbu_pkg::PROT_RST});
    reset_chip();
    chk("secured", {31'h0, secured}, 32'h1);
    // mismatch, zero, ones, early clear, wrong order, extra word, debug single chip
    for (c = 0; c < 7; c++) begin
      reset_chip();
      n = (c == 3) ? 3 : (c == 5) ? 5 : 4;
      bad = (c == 0) ? key_of(0) ^ 16'(1 << ($urandom % 12)) :
        (c == 1) ? fsbu_pkg::KEY_ZERO : fsbu_pkg::KEY_ONES;
      {dbg, ssc} <= {2{c == 6}};
      repeat (3) @(posedge clk);
      attempt(n, (c == 4) ? 1 : 0, (c < 3) ? c : 9, bad);
      chk("secured", {31'h0, secured}, 32'h1);
      attempt(4, 0, 9, 16'h0);
      chk("secured", {31'h0, secured}, 32'h1);
    end
    {dbg, ssc} <= 2'h0;
    reset_chip();
    attempt(4, 0, 9, 16'h0);
    chk("secured", {31'h0, secured}, 32'h0);
    for (c = 0; c < 10; c++) begin
      d = (c < 2) ? 32'h80 | c : $urandom & 32'hC3;
      u_cpu.wr(12'h004, d, r);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, d[1:0] == 2'h0 && (d[7] || d[6])});
    end
    // unsecured with the top sector open, so a key word may be reprogrammed
    u_cpu.wr(12'h100, 32'h4321, r);
    u_cpu.wr(12'h010, {24'h0, fsbu_pkg::CMD_PROG}, r);
    u_cpu.wr(12'h00C, 32'h80, r);
    repeat (40) @(posedge clk);
    u_cpu.rd(12'h100, d, r);
    chk("newkey", d, 32'h4321);
    // second launch is cut short by a chip reset
    for (c = 0; c < 2; c++) begin
      u_cpu.wr(12'h100, 32'h1234, r);
      u_cpu.wr(12'h010, {24'h0, fsbu_pkg::CMD_VERIFY}, r);
      u_cpu.wr(12'h00C, 32'h80, r);
      u_cpu.rd(12'h00C, d, r);
      chk("busy", d & 32'hD0, 32'h0);
      if (c == 0) repeat (40) @(posedge clk);
      else reset_chip();
      u_cpu.rd(12'h00C, d, r);
      chk("idle", d & 32'hD0, 32'hC0);
    end
    // secured: program refused; then debug in single chip refuses all but mass erase
    for (c = 0; c < 2; c++) begin
      u_cpu.wr(12'h00C, 32'h10, r);
      {dbg, ssc} <= {2{c == 1}};
      repeat (3) @(posedge clk);
      u_cpu.wr(12'h100, 32'h1111, r);
      u_cpu.wr(12'h010, {24'h0, (c == 1) ? fsbu_pkg::CMD_VERIFY : fsbu_pkg::CMD_PROG}, r);
      u_cpu.wr(12'h00C, 32'h80, r);
      u_cpu.rd(12'h00C, d, r);
      chk("refused", d & 32'hD0, 32'hD0);
    end
    end_sim();
  end
endmodule : tb
